// >>> verilog/fce_checker.sv
// Flash command sequencer with access error and protection checking
`timescale 1ns/1ps

module fce_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire fce_pkg::fce_axi_req_s axi_req,
	output fce_pkg::fce_axi_rsp_s axi_rsp,
	input wire logic [7:0] prot_load_value,
	output logic core_hold,
	output logic flash_irq,
	output logic high_voltage_on
);
	import fce_pkg::*;

	fce_state_s q;
	fce_state_s next_q;

	// ----------------------------------------
	// Write decode helpers
	// ----------------------------------------
	logic wr_go;
	logic rd_go;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [7:0] wa;
	logic any_err;
	logic cmd_ok;
	logic [15:0] aaddr;
	logic ablk;
	logic aprot;

	assign wd = q.w_data;
	assign ws = q.w_strb;
	assign wa = q.aw_addr;
	assign wr_go = q.aw_hold && q.w_hold && !q.bvalid;
	assign rd_go = axi_req.arvalid && !q.rvalid;
	assign any_err = |q.access_error_flag || |q.protection_violation_flag;
	assign aaddr = wd[15:0];
	assign ablk = aaddr[15];
	assign aprot = q.prot[7] && (aaddr >= PROT_BASE);

	always_comb begin
		logic [7:0] mode;
		logic b;
		logic err;
		logic viol;
		mode = wd[7:0];
		b = q.bank;
		err = 1'b0;
		viol = 1'b0;
		next_q = q;
		cmd_ok = (wd[7:0] == CMD_VERIFY) || (wd[7:0] == CMD_PROG)
			|| (wd[7:0] == CMD_SECT) || (wd[7:0] == CMD_MASS);

		// Channel capture; address and data may come in either order
		if (axi_req.awvalid && !q.aw_hold) begin
			next_q.aw_hold = 1'b1;
			next_q.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !q.w_hold) begin
			next_q.w_hold = 1'b1;
			next_q.w_data = axi_req.wdata;
			next_q.w_strb = axi_req.wstrb;
		end
		if (q.bvalid && axi_req.bready) begin
			next_q.bvalid = 1'b0;
		end
		if (q.rvalid && axi_req.rready) begin
			next_q.rvalid = 1'b0;
		end

		// ----------------------------------------
		// Reads: never touch the error flags
		// ----------------------------------------
		if (rd_go) begin
			next_q.rvalid = 1'b1;
			next_q.rresp = 2'b00;
			unique case (axi_req.araddr)
				OFF_CLKDIV: next_q.rdata = {23'h0, q.div_loaded, q.clkdiv};
				OFF_CONFIG: next_q.rdata = {24'h0, q.config_bits};
				OFF_STATUS: next_q.rdata = {24'h0, q.beif[b], q.command_complete_flag[b],
					q.protection_violation_flag[b], q.access_error_flag[b], 4'h0};
				OFF_CMD: next_q.rdata = {24'h0, q.cmd};
				OFF_PROT: next_q.rdata = {24'h0, q.prot};
				OFF_SUPER: next_q.rdata = {31'h0, q.super_mode};
				OFF_SADDR: next_q.rdata = {16'h0, q.addr};
				OFF_SDATA: next_q.rdata = {16'h0, q.data};
				// Array reads while executing return invalid data
				OFF_ARRAY: next_q.rdata = q.st[4] ? 32'hFFFF_FFFF
					: {16'h0, q.data};
				default: begin
					next_q.rdata = 32'h0000_0000;
					next_q.rresp = 2'b10;
				end
			endcase
		end

		// ----------------------------------------
		// Writes and sequence checks
		// ----------------------------------------
		if (wr_go) begin
			next_q.aw_hold = 1'b0;
			next_q.w_hold = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = 2'b00;
			// Mid-sequence, only the expected register may be written
			if (q.st[2] && wa != OFF_CMD) begin
				err = 1'b1;
			end else if (q.st[3] && wa != OFF_STATUS) begin
				err = 1'b1;
			end else if (q.super_mode && q.sup_addr_seen
				&& wa != OFF_SDATA) begin
				err = 1'b1;
			end else begin
				unique case (wa)
					OFF_CLKDIV: begin
						next_q.clkdiv = wd[7:0];
						next_q.div_loaded = 1'b1;
					end
					OFF_CONFIG: begin
						next_q.config_bits = wd[7:0];
						next_q.bank = wd[CF_BANK_SELECT_BIT];
					end
					OFF_PROT: begin
						// Writable only in debug; otherwise ignored
						if (q.config_bits[1] || q.page[7]) begin
							next_q.prot = wd[7:0];
						end
					end
					OFF_MODE: begin
						next_q.page = wd[15:8];
					end
					OFF_SUPER: next_q.super_mode = wd[0];
					OFF_SADDR: begin
						if (q.super_mode) begin
							next_q.sup_addr_seen = 1'b1;
							next_q.addr = aaddr;
							if (aaddr[0]) begin
								err = 1'b1;
							end
						end
					end
					OFF_SDATA: begin
						if (!q.super_mode || !q.sup_addr_seen) begin
							err = 1'b1;
						end else begin
							next_q.sup_addr_seen = 1'b0;
							next_q.data = wd[15:0];
							next_q.st = FCE_WORD;
							viol = aprot;
						end
					end
					OFF_ARRAY: begin
						next_q.addr = aaddr;
						next_q.data = wd[31:16];
						if (!q.div_loaded) begin
							err = 1'b1;
						end else if (ws != 4'h3 || aaddr[0]) begin
							err = 1'b1;
						end else if (!q.beif[b]) begin
							err = 1'b1;
						end else if (!q.st[1]) begin
							err = 1'b1;
						end else if (wd[AR_BYTE+MD_SPECIAL] && aaddr
							>= PAGE_WIN_LO && aaddr <= PAGE_WIN_HI
							&& q.page[0] != b) begin
							err = 1'b1;
						end else if (!wd[AR_BYTE+MD_SPECIAL]
							&& ablk != b) begin
							err = 1'b1;
						end else begin
							next_q.st = FCE_WORD;
							viol = aprot;
						end
					end
					OFF_CMD: begin
						if (q.st[3] || q.st[4]) begin
							err = 1'b1;
						end else if (!cmd_ok) begin
							err = 1'b1;
						end else if (mode == CMD_MASS
							&& |q.prot) begin
							viol = 1'b1;
						end else if (q.config_bits[2] && mode != CMD_MASS
							&& (mode != CMD_VERIFY || q.config_bits[3])) begin
							err = 1'b1;
						end else if (q.st[2]) begin
							next_q.cmd = mode;
							next_q.st = FCE_CMD;
						end else begin
							err = 1'b1;
						end
					end
					OFF_STATUS: begin
						// Write one to clear error flags
						if (wd[ST_ACCESS_ERROR_FLAG]) begin
							next_q.access_error_flag[b] = 1'b0;
						end
						if (wd[ST_PROTECTION_VIOLATION_FLAG]) begin
							next_q.protection_violation_flag[b] = 1'b0;
						end
						if (!wd[ST_BEIF] && !q.st[1]) begin
							err = 1'b1;
						end else if (wd[ST_BEIF] && q.st[3]) begin
							if (any_err) begin
								err = 1'b1;
							end else begin
								next_q.st = FCE_EXEC;
								next_q.cnt = EXEC_CYCLES;
								next_q.beif[b] = 1'b0;
								next_q.command_complete_flag[b] = 1'b0;
							end
						end
					end
					default: next_q.bresp = 2'b10;
				endcase
			end
		end

		// Abort sets the flag in the selected bank, set wins over clear
		if (err || viol) begin
			if (err) begin
				next_q.access_error_flag[b] = 1'b1;
			end
			if (viol) begin
				next_q.protection_violation_flag[b] = 1'b1;
			end
			next_q.st = FCE_IDLE;
			next_q.sup_addr_seen = 1'b0;
		end

		// ----------------------------------------
		// Sequencer timing, reset load, stop
		// ----------------------------------------
		next_q.stop_prev = q.config_bits[MD_STOP];
		unique case (q.st)
			FCE_LOAD: begin
				next_q.prot = prot_load_value;
				if (q.cnt == 8'h00) begin
					next_q.st = FCE_IDLE;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			FCE_EXEC: begin
				// Wait mode does not stall execution
				if (q.config_bits[MD_STOP]) begin
					next_q.st = FCE_IDLE;
					next_q.command_complete_flag = 2'b11;
					next_q.access_error_flag = q.access_error_flag | ~q.command_complete_flag;
				end else if (q.cnt == 8'h00) begin
					next_q.st = FCE_IDLE;
					next_q.command_complete_flag = 2'b11;
					next_q.beif = 2'b11;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			FCE_IDLE, FCE_WORD, FCE_CMD: begin
			end
		endcase
		if (q.stop_prev && !q.config_bits[MD_STOP]) begin
			next_q.beif = 2'b11;
			if (!q.st[4]) begin
				next_q.st = FCE_IDLE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= FCE_LOAD;
			q.cnt <= LOAD_CYCLES;
			q.prot <= PROT_RST;
			q.beif <= 2'b11;
			q.command_complete_flag <= 2'b11;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign axi_rsp.awready = !q.aw_hold;
	assign axi_rsp.wready = !q.w_hold;
	assign axi_rsp.bvalid = q.bvalid;
	assign axi_rsp.bresp = q.bresp;
	assign axi_rsp.arready = !q.rvalid;
	assign axi_rsp.rvalid = q.rvalid;
	assign axi_rsp.rdata = q.rdata;
	assign axi_rsp.rresp = q.rresp;
	assign core_hold = q.st[0];
	assign high_voltage_on = q.st[4];
	assign flash_irq = (q.beif[q.bank] && q.config_bits[CF_BEIE])
		|| (q.command_complete_flag[q.bank] && q.config_bits[CF_COMMAND_COMPLETE_IRQ_ENABLE]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	lock_launch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		any_err && q.st[3] |=> !q.st[4])
		else $error("Launch while error flag set");
	stop_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
		q.st[4] && q.config_bits[MD_STOP] |=> q.command_complete_flag == 2'b11
		&& !high_voltage_on)
		else $error("Stop did not abort command");
	reset_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> core_hold)
		else $error("Core not held after reset");
	irq_bank_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_irq |-> q.beif[q.bank] || q.command_complete_flag[q.bank])
		else $error("Interrupt without selected flag");
	launch_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!q.st[4] ##1 q.st[4] |-> !q.command_complete_flag[q.bank])
		else $error("Complete flag not cleared on launch");
	read_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go && !wr_go && !q.st[4] |=> q.access_error_flag == $past(q.access_error_flag))
		else $error("Read changed access error");
	exec_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(q.st[4]) |-> ##[1:20] !q.st[4])
		else $error("Command did not finish");
	zero_beif_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wa == OFF_STATUS && !wd[ST_BEIF] && !q.st[1]
		&& !q.st[0] |=> |q.access_error_flag)
		else $error("Abort did not flag error");
	clear_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wa == OFF_STATUS && q.st[1] && wd[ST_ACCESS_ERROR_FLAG]
		&& wd[ST_BEIF] |=> !q.access_error_flag[q.bank])
		else $error("Write one did not clear error");
	keep_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wa == OFF_STATUS && q.st[1] && !wd[ST_ACCESS_ERROR_FLAG]
		&& wd[ST_BEIF] |=> q.access_error_flag == $past(q.access_error_flag))
		else $error("Write zero changed error flag");
	div_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wa == OFF_ARRAY && !q.div_loaded
		|=> q.access_error_flag[q.bank] && !q.st[2])
		else $error("Array write accepted before divider");

endmodule

// >>> verilog/fce_pkg.sv
// Package: constants and carrier types for the flash command error checker
package fce_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CLKDIV = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CMD = 8'h0C;
	localparam logic [7:0] OFF_PROT = 8'h10;
	localparam logic [7:0] OFF_SUPER = 8'h14;
	localparam logic [7:0] OFF_SADDR = 8'h18;
	localparam logic [7:0] OFF_SDATA = 8'h1C;
	localparam logic [7:0] OFF_ARRAY = 8'h20;
	localparam logic [7:0] OFF_MODE = 8'h24;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_BEIF = 7;
	localparam int ST_COMMAND_COMPLETE_FLAG = 6;
	localparam int ST_PROTECTION_VIOLATION_FLAG = 5;
	localparam int ST_ACCESS_ERROR_FLAG = 4;
	localparam int CF_BEIE = 7;
	localparam int CF_COMMAND_COMPLETE_IRQ_ENABLE = 6;
	localparam int CF_BANK_SELECT_BIT = 0;
	localparam int AR_BYTE = 16;
	localparam int MD_SPECIAL = 0;
	localparam int MD_SECURE = 1;
	localparam int MD_NONSEC_SRC = 2;
	localparam int MD_DEBUG = 3;
	localparam int MD_SSC = 4;
	localparam int MD_WAIT = 5;
	localparam int MD_STOP = 6;

	// ----------------------------------------
	// Commands, reset values and counts
	// ----------------------------------------
	localparam logic [7:0] CMD_VERIFY = 8'h05;
	localparam logic [7:0] CMD_PROG = 8'h20;
	localparam logic [7:0] CMD_SECT = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] LOAD_CYCLES = 8'h04;
	localparam logic [7:0] EXEC_CYCLES = 8'h10;
	localparam logic [15:0] PAGE_WIN_LO = 16'h8000;
	localparam logic [15:0] PAGE_WIN_HI = 16'hBFFF;
	localparam logic [15:0] PROT_BASE = 16'hC000;

	typedef enum logic [4:0] {
		FCE_LOAD = 5'b00001,
		FCE_IDLE = 5'b00010,
		FCE_WORD = 5'b00100,
		FCE_CMD = 5'b01000,
		FCE_EXEC = 5'b10000
	} fce_state_e;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} fce_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fce_axi_rsp_s;

	typedef struct packed {
		fce_state_e st;
		logic [7:0] cnt;
		logic div_loaded;
		logic [7:0] clkdiv;
		logic [7:0] config_bits;
		logic [7:0] prot;
		logic [7:0] page;
		logic super_mode;
		logic sup_addr_seen;
		logic [15:0] addr;
		logic [15:0] data;
		logic [7:0] cmd;
		logic [1:0] beif;
		logic [1:0] command_complete_flag;
		logic [1:0] access_error_flag;
		logic [1:0] protection_violation_flag;
		logic bank;
		logic stop_prev;
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fce_state_s;

endpackage

// >>> tb/fce_flash_model.sv
// Flash block 0 model that presents the protection byte during load
`timescale 1ns/1ps

module fce_flash_model (
	input wire logic aclk,
	input wire logic core_hold,
	input wire logic [7:0] prot_image,
	output logic [7:0] prot_load_value
);
	logic [7:0] wobble = 8'h5a;

	// Outside the load the byte wobbles, so a late sample cannot pass
	always_ff @(posedge aclk) begin
		wobble <= ~wobble;
	end

	assign prot_load_value = core_hold ? prot_image : wobble;
endmodule

// >>> tb/flash_command_error_checker_tb.sv
// Self-checking bench for the flash command error checker
`timescale 1ns/1ps

module flash_command_error_checker_tb;
	import fce_pkg::*;
	localparam logic [31:0] FL_MASK = 32'h0000_00f0;
	localparam logic [31:0] ST_OK = 32'h0000_00c0;
	localparam logic [31:0] ST_ERR = 32'h0000_00d0;
	localparam logic [31:0] ST_VIOL = 32'h0000_00e0;
	localparam logic [31:0] CLR = 32'h0000_00b0;
	localparam logic [31:0] GO = 32'h0000_0080;
	logic aclk;
	logic aresetn;
	fce_axi_req_s req;
	fce_axi_rsp_s rsp;
	logic [7:0] prot_image;
	logic [7:0] prot_load_value;
	logic core_hold;
	logic flash_irq;
	logic high_voltage_on;
	logic [31:0] rv;
	logic [1:0] rr;
	logic [15:0] lfsr;
	logic [15:0] a;
	// Program comes after the sector erase on the same word
	logic [7:0] cmds [4] = '{CMD_VERIFY, CMD_SECT, CMD_PROG, CMD_MASS};
	int n_errors;
	int total_checks;

	fce_checker dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.axi_req(req),
		.axi_rsp(rsp),
		.prot_load_value(prot_load_value),
		.core_hold(core_hold),
		.flash_irq(flash_irq),
		.high_voltage_on(high_voltage_on)
	);

	fce_flash_model flash0 (
		.aclk(aclk),
		.core_hold(core_hold),
		.prot_image(prot_image),
		.prot_load_value(prot_load_value)
	);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ----------------------------------------
	// Bus and checking tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Ready is looked at on the falling edge so the handshake edge is clean
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= ad;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		while (aw || w) begin
			@(negedge aclk);
			if (rsp.awready) aw = 1'b0;
			if (rsp.wready) w = 1'b0;
			@(posedge aclk);
			if (!aw) req.awvalid <= 1'b0;
			if (!w) req.wvalid <= 1'b0;
		end
		@(negedge aclk);
		while (!rsp.bvalid) @(negedge aclk);
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] ad);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= ad;
		@(negedge aclk);
		while (!rsp.arready) @(negedge aclk);
		@(posedge aclk);
		req.arvalid <= 1'b0;
		@(negedge aclk);
		while (!rsp.rvalid) @(negedge aclk);
		rv = rsp.rdata;
		rr = rsp.rresp;
		@(posedge aclk);
	endtask

	task automatic flags(input string nm, input logic [31:0] e);
		rd(OFF_STATUS);
		chk(nm, rv & FL_MASK, e);
	endtask

	task automatic exp_err;
		flags("status_err", ST_ERR);
		wr(OFF_STATUS, CLR, 4'hf);
		flags("status_clr", ST_OK);
	endtask

	task automatic arr(input logic [15:0] ad);
		wr(OFF_ARRAY, {16'h0000, ad}, 4'h3);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(OFF_CMD, {24'h00_0000, c}, 4'hf);
	endtask

	// Even word inside the paged window, which is block 1 in normal mode
	task automatic rnd_addr;
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		a = {2'b10, lfsr[12:0], 1'b0};
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		rv = '0;
		while (rv[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 60) begin
			rd(OFF_STATUS);
			n++;
		end
		chk("done_flags", rv & FL_MASK, ST_OK);
		@(negedge aclk);
		chk("hv_off", high_voltage_on, 1'b0);
	endtask

	task automatic do_reset(input logic [7:0] p);
		int n;
		prot_image <= p;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("hold_on", core_hold, 1'b1);
		n = 0;
		while (core_hold !== 1'b0 && n < 20) begin
			@(negedge aclk);
			n++;
		end
		chk("hold_off", core_hold, 1'b0);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		aresetn = 1'b0;
		prot_image = 8'h00;
		lfsr = 16'h0035;
		a = 16'h8000;
		n_errors = 0;
		total_checks = 0;
		do_reset(8'h00);
		flags("status_rst", ST_OK);
		chk("irq_rst", flash_irq, 1'b0);
		arr(16'h8000);
		flags("no_div", ST_ERR);
		wr(OFF_STATUS, GO, 4'hf);
		flags("w0_keeps", ST_ERR);
		wr(OFF_STATUS, CLR, 4'hf);
		flags("w1_clears", ST_OK);
		wr(OFF_CLKDIV, 32'h0000_0014, 4'hf);
		rd(OFF_CLKDIV);
		chk("div_loaded", rv[8], 1'b1);
		// Page window addresses belong to block 1 in normal mode
		wr(OFF_CONFIG, 32'h0000_0001, 4'hf);
		rnd_addr();
		wr(OFF_ARRAY, {16'h0000, a}, 4'h1);
		exp_err();
		arr(a | 16'h0001);
		exp_err();
		arr(a);
		arr(a);
		exp_err();
		arr(a);
		wr(OFF_CONFIG, 32'h0000_0000, 4'hf);
		exp_err();
		arr(a);
		cmd(CMD_PROG);
		cmd(CMD_PROG);
		exp_err();
		arr(a);
		cmd(8'h77);
		exp_err();
		arr(a);
		cmd(CMD_SECT);
		wr(OFF_CONFIG, 32'h0000_0000, 4'hf);
		exp_err();
		arr(a);
		wr(OFF_STATUS, 32'h0000_0000, 4'hf);
		exp_err();
		for (int i = 0; i < 4; i++) begin
			if (cmds[i] != CMD_PROG) begin
				rnd_addr();
			end
			arr(a);
			rd(OFF_STATUS);
			chk("rd_no_err", rv[ST_ACCESS_ERROR_FLAG], 1'b0);
			cmd(cmds[i]);
			wr(OFF_STATUS, GO, 4'hf);
			@(negedge aclk);
			chk("hv_on", high_voltage_on, 1'b1);
			rd(OFF_STATUS);
			chk("cc_low", rv[ST_COMMAND_COMPLETE_FLAG], 1'b0);
			wait_done();
		end
		arr(a);
		arr(a);
		arr(a);
		cmd(CMD_PROG);
		wr(OFF_STATUS, GO, 4'hf);
		@(negedge aclk);
		chk("locked_hv", high_voltage_on, 1'b0);
		exp_err();
		wr(OFF_CONFIG, 32'h0000_0081, 4'hf);
		@(negedge aclk);
		chk("irq_be", flash_irq, 1'b1);
		wr(OFF_CONFIG, 32'h0000_0001, 4'hf);
		@(negedge aclk);
		chk("irq_masked", flash_irq, 1'b0);
		rd(8'h30);
		chk("unmapped", {30'h0, rr}, 32'h0000_0002);
		arr(a);
		cmd(CMD_SECT);
		wr(OFF_STATUS, GO, 4'hf);
		do_reset(8'h80);
		chk("abort_hv", high_voltage_on, 1'b0);
		flags("abort_st", ST_OK);
		wr(OFF_CLKDIV, 32'h0000_0014, 4'hf);
		wr(OFF_CONFIG, 32'h0000_0001, 4'hf);
		arr(16'hc000);
		flags("prot_addr", ST_VIOL);
		wr(OFF_STATUS, CLR, 4'hf);
		arr(16'h8000);
		cmd(CMD_MASS);
		flags("prot_mass", ST_VIOL);
		wr(OFF_STATUS, CLR, 4'hf);
		flags("prot_clr", ST_OK);
		tally_and_finish();
	end

	// A few hundred cycles cover the sequence; 20000 cycles is a hang
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		tally_and_finish();
	end
endmodule
